//--- design/frt_timer_core.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// (R1) Tick divides CPU clock by 2, 4, 8
// (R2) Sixteen bit up-counter advances per tick
// (R3) Two views; only main low clears flag
// (R4) Low byte write forces FFFCh
// (R5) Reset value FFFCh, only value loaded
// (R6) Software reads high byte first, latching low
// (R7) Buffered low byte frozen until low read
// (R8) Lone low read returns live byte
// (R9) Wrap FFFFh to 0000h sets overflow flag
// (R10) Request needs flag, enable, mask clear
// (R11) Flag clears after status read, low access
// (R12) Idle mode keeps counting
// (R13) Halt freezes counter, resumes on interrupt
// (R14) Select both ones uses external pin
// (R15) Edge select picks rising or falling
// (R16) Updates synchronised to CPU clock
// (R17) External edges spaced four CPU clocks
// (R18) Unbonded timer input reads as one
// (R19) Two instances stay in step after reset
// (R20) Tick strobe and count given to functions
module frt_timer_core (
	input  wire logic                 CLK,
	input  wire logic                 NRST,
	input  wire frt_pkg::frt_config_t CONFIG,
	input  wire frt_pkg::frt_access_t ACCESS,
	input  wire logic                 EXT_TIMER_CLOCK_PIN,
	output logic [7:0]                COUNT_HIGH_BYTE,
	output logic [7:0]                COUNT_LOW_BYTE,
	output logic [7:0]                ALT_COUNT_HIGH_BYTE,
	output logic [7:0]                ALT_COUNT_LOW_BYTE,
	output logic                      OVERFLOW_FLAG,
	output logic                      OVERFLOW_IRQ,
	output logic                      TIMER_TICK,
	output logic [15:0]               COUNT_VALUE
);
	import frt_pkg::*;

	logic [15:0]   count_r;
	logic [15:0]   count_nxt;
	logic [7:0]    low_buf_r;
	logic [7:0]    low_buf_nxt;
	frt_rd_state_t rd_state_r;
	frt_rd_state_t rd_state_nxt;
	logic          flag_r;
	logic          flag_nxt;
	logic          armed_r;
	logic          armed_nxt;
	logic          tick;
	logic          wrap;
	logic          any_high_rd;
	logic          any_low_rd;
	logic          low_wr;
	logic          main_low_acc;

	frt_tick_gen u_tick (
		.CLK             (CLK),
		.NRST            (NRST),
		.CLOCK_SELECT    (CONFIG.clock_select),
		.EXT_EDGE_RISING (CONFIG.ext_edge_rising),
		.EXT_PIN         (EXT_TIMER_CLOCK_PIN),
		.EXT_PIN_BONDED  (CONFIG.ext_pin_bonded),
		.HALT_MODE       (CONFIG.halt_mode),
		.TICK            (tick)
	);

	assign any_high_rd  = ACCESS.rd_high | ACCESS.rd_alt_high;
	assign any_low_rd   = ACCESS.rd_low | ACCESS.rd_alt_low;
	assign low_wr       = ACCESS.wr_low | ACCESS.wr_alt_low;
	assign main_low_acc = ACCESS.rd_low | ACCESS.wr_low; // R3
	assign wrap         = tick & (count_r == FRT_MAX_COUNT);

	// Counter
	always_comb begin
		count_nxt = count_r;
		if (low_wr) begin
			count_nxt = FRT_RESET_COUNT; // R4 R5
		end else if (tick) begin
			count_nxt = count_r + 16'h0001; // R2 R12
		end
	end

	// Sixteen bit read sequencing, shared by both views
	always_comb begin
		rd_state_nxt = rd_state_r;
		low_buf_nxt  = low_buf_r;
		case (rd_state_r)
			FRT_RD_IDLE: begin
				if (any_high_rd) begin
					rd_state_nxt = FRT_RD_LATCHD; // R6
					low_buf_nxt  = count_r[7:0];
				end
			end
			FRT_RD_LATCHD: begin
				if (any_low_rd) begin
					rd_state_nxt = FRT_RD_IDLE;
				end
			end
			default: begin
				rd_state_nxt = FRT_RD_IDLE;
			end
		endcase
	end

	// Overflow flag with two-step clear; set wins
	always_comb begin
		flag_nxt  = flag_r;
		armed_nxt = armed_r;
		if (ACCESS.rd_flags && flag_r) begin
			armed_nxt = 1'b1; // R11
		end
		if (main_low_acc && armed_r) begin
			flag_nxt  = 1'b0; // R11
			armed_nxt = 1'b0;
		end
		if (wrap) begin
			flag_nxt = 1'b1; // R9
		end
		if (!flag_nxt) begin
			armed_nxt = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			count_r    <= FRT_RESET_COUNT; // R5 R19
			low_buf_r  <= 8'h00;
			rd_state_r <= FRT_RD_IDLE;
			flag_r     <= 1'b0;
			armed_r    <= 1'b0;
		end else begin
			count_r    <= count_nxt;
			low_buf_r  <= low_buf_nxt;
			rd_state_r <= rd_state_nxt;
			flag_r     <= flag_nxt;
			armed_r    <= armed_nxt;
		end
	end

	// Read data: low byte frozen while latched, live otherwise
	always_comb begin
		COUNT_HIGH_BYTE     = count_r[15:8];
		ALT_COUNT_HIGH_BYTE = count_r[15:8];
		if (rd_state_r == FRT_RD_LATCHD) begin
			COUNT_LOW_BYTE = low_buf_r; // R7
		end else begin
			COUNT_LOW_BYTE = count_r[7:0]; // R8
		end
		ALT_COUNT_LOW_BYTE = COUNT_LOW_BYTE; // R3
	end

	assign OVERFLOW_FLAG = flag_r;
	assign OVERFLOW_IRQ  = flag_r & CONFIG.overflow_irq_enable & ~CONFIG.cpu_irq_mask; // R10
	assign TIMER_TICK    = tick; // R20
	assign COUNT_VALUE   = count_r; // R20
endmodule : frt_timer_core
`default_nettype wire

//--- inc/frt_pkg.sv
package frt_pkg;

	localparam logic [15:0] FRT_RESET_COUNT = 16'hFFFC;
	localparam logic [15:0] FRT_MAX_COUNT   = 16'hFFFF;
	localparam logic [1:0]  FRT_SEL_DIV2    = 2'h0;
	localparam logic [1:0]  FRT_SEL_DIV4    = 2'h1;
	localparam logic [1:0]  FRT_SEL_DIV8    = 2'h2;
	localparam logic [1:0]  FRT_SEL_EXT     = 2'h3;
	localparam logic [2:0]  FRT_DIV2_MASK   = 3'h1;
	localparam logic [2:0]  FRT_DIV4_MASK   = 3'h3;
	localparam logic [2:0]  FRT_DIV8_MASK   = 3'h7;
	localparam int          FRT_SYNC_STAGES = 2;

	// Byte access strobes from the CPU side, one cycle each
	typedef struct packed {
		logic rd_high;
		logic rd_low;
		logic wr_low;
		logic rd_alt_high;
		logic rd_alt_low;
		logic wr_alt_low;
		logic rd_flags;
	} frt_access_t;

	// Configuration bits
	typedef struct packed {
		logic [1:0] clock_select;
		logic       ext_edge_rising;
		logic       overflow_irq_enable;
		logic       cpu_irq_mask;
		logic       halt_mode;
		logic       ext_pin_bonded;
	} frt_config_t;

	typedef enum logic [1:0] {
		FRT_RD_IDLE   = 2'b01,
		FRT_RD_LATCHD = 2'b10
	} frt_rd_state_t;

endpackage : frt_pkg

//--- design/frt_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module frt_tick_gen (
	input  wire logic                 CLK,
	input  wire logic                 NRST,
	input  wire logic [1:0]           CLOCK_SELECT,
	input  wire logic                 EXT_EDGE_RISING,
	input  wire logic                 EXT_PIN,
	input  wire logic                 EXT_PIN_BONDED,
	input  wire logic                 HALT_MODE,
	output logic                      TICK
);
	import frt_pkg::*;

	logic [2:0] prescale_r;
	logic [2:0] prescale_nxt;
	logic       sync1_r;
	logic       sync2_r;
	logic       ext_prev_r;
	logic       ext_prev_nxt;
	logic       ext_level;
	logic [2:0] div_mask;
	logic       ext_edge;

	// Unbonded pin reads as one
	assign ext_level = EXT_PIN_BONDED ? EXT_PIN : 1'b1; // R18

	always_comb begin
		case (CLOCK_SELECT)
			FRT_SEL_DIV2: div_mask = FRT_DIV2_MASK;
			FRT_SEL_DIV4: div_mask = FRT_DIV4_MASK;
			default:      div_mask = FRT_DIV8_MASK;
		endcase
	end

	always_comb begin
		prescale_nxt = HALT_MODE ? prescale_r : prescale_r + 3'h1; // R13
		ext_prev_nxt = sync2_r;
		ext_edge     = EXT_EDGE_RISING ? (sync2_r & ~ext_prev_r) : (~sync2_r & ext_prev_r); // R15
		if (HALT_MODE) begin
			TICK = 1'b0; // R13
		end else if (CLOCK_SELECT == FRT_SEL_EXT) begin
			TICK = ext_edge; // R14 R16
		end else begin
			TICK = ((prescale_r & div_mask) == div_mask); // R1 R19
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			prescale_r <= 3'h0;
			sync1_r    <= 1'b1;
			sync2_r    <= 1'b1;
			ext_prev_r <= 1'b1;
		end else begin
			prescale_r <= prescale_nxt;
			sync1_r    <= ext_level;
			sync2_r    <= sync1_r;
			ext_prev_r <= ext_prev_nxt;
		end
	end
endmodule : frt_tick_gen
`default_nettype wire

//--- testbench/frt_timer_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module frt_timer_core_chk (
	input wire logic                 CLK,
	input wire logic                 NRST,
	input wire frt_pkg::frt_config_t CONFIG,
	input wire frt_pkg::frt_access_t ACCESS,
	input wire logic [7:0]           COUNT_LOW_BYTE,
	input wire logic                 OVERFLOW_FLAG,
	input wire logic                 OVERFLOW_IRQ,
	input wire logic                 TIMER_TICK,
	input wire logic [15:0]          COUNT_VALUE
);
	import frt_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	wire ld = ACCESS.wr_low || ACCESS.wr_alt_low;
	wire wrap = TIMER_TICK && COUNT_VALUE == FRT_MAX_COUNT;
	logic seq_open_r;
	// Mirrors the open sixteen bit read sequence; repeat high reads keep it
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			seq_open_r <= 1'b0;
		end else if (!seq_open_r) begin
			seq_open_r <= ACCESS.rd_high || ACCESS.rd_alt_high;
		end else begin
			seq_open_r <= !(ACCESS.rd_low || ACCESS.rd_alt_low);
		end
	end
	sequence s_arm;
		ACCESS.rd_flags && OVERFLOW_FLAG;
	endsequence
	sequence s_clr;
		s_arm ##[1:4] (ACCESS.rd_low || ACCESS.wr_low) && !wrap;
	endsequence
	a_load_count: assert property (ld |=> COUNT_VALUE == FRT_RESET_COUNT)
		else $error("count not loaded");
	a_tick_step: assert property (TIMER_TICK && !ld |=> COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001)
		else $error("count did not step");
	a_count_hold: assert property (!TIMER_TICK && !ld |=> $stable(COUNT_VALUE))
		else $error("count moved without tick");
	a_wrap_flag: assert property (wrap |=> OVERFLOW_FLAG)
		else $error("wrap left flag clear");
	a_flag_keep: assert property (OVERFLOW_FLAG && !ACCESS.rd_low && !ACCESS.wr_low |=> OVERFLOW_FLAG)
		else $error("flag lost");
	a_irq_gate: assert property (OVERFLOW_IRQ == (OVERFLOW_FLAG && CONFIG.overflow_irq_enable && !CONFIG.cpu_irq_mask))
		else $error("irq wrong");
	a_flag_clear: assert property (s_clr |=> !OVERFLOW_FLAG)
		else $error("flag not cleared");
	a_latch_low: assert property ((ACCESS.rd_high || ACCESS.rd_alt_high) && !seq_open_r |=> COUNT_LOW_BYTE == 8'($past(COUNT_VALUE)))
		else $error("low byte not buffered");
endmodule : frt_timer_core_chk
bind frt_timer_core frt_timer_core_chk u_chk (.CLK(CLK), .NRST(NRST), .CONFIG(CONFIG),
	.ACCESS(ACCESS), .COUNT_LOW_BYTE(COUNT_LOW_BYTE), .OVERFLOW_FLAG(OVERFLOW_FLAG),
	.OVERFLOW_IRQ(OVERFLOW_IRQ), .TIMER_TICK(TIMER_TICK), .COUNT_VALUE(COUNT_VALUE));
`default_nettype wire

//--- testbench/frt_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module frt_cpu_model (
	input wire logic           CLK,
	input wire logic [6:0]     REQ,
	input wire logic           EXT_RUN,
	output var frt_pkg::frt_access_t ACCESS,
	output var logic           EXT_PIN
);
	import frt_pkg::*;
	logic [1:0] gap_r = 2'h0;
	initial ACCESS = '0;
	initial EXT_PIN = 1'b0;
	// One-cycle strobes, high byte issued before low by the caller
	always @(negedge CLK) begin
		ACCESS <= REQ;
		gap_r <= gap_r + 2'h1;
		if (EXT_RUN && gap_r == 2'h3) EXT_PIN <= !EXT_PIN;
	end
endmodule : frt_cpu_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import frt_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic run = 1'b0;
	logic [6:0] req = '0;
	frt_config_t cfg = '{2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	frt_access_t acc;
	logic pin, flag, irq;
	logic [7:0] hb, lb, alb, ahb, l;
	logic [15:0] cnt, ref_cnt;
	logic [2:0] psc;
	int err_total = 0;
	int checked = 0;
	int edges = 0;
	wire [2:0] msk = cfg.clock_select == 2'h0 ? FRT_DIV2_MASK :
		cfg.clock_select == 2'h1 ? FRT_DIV4_MASK : FRT_DIV8_MASK;
	always #20 clk = ~clk;
	always @(pin) if (pin == cfg.ext_edge_rising) edges++;
	frt_cpu_model u_cpu (.CLK(clk), .REQ(req), .EXT_RUN(run), .ACCESS(acc), .EXT_PIN(pin));
	frt_timer_core u_dut (.CLK(clk), .NRST(nrst), .CONFIG(cfg), .ACCESS(acc),
		.EXT_TIMER_CLOCK_PIN(pin), .COUNT_HIGH_BYTE(hb), .COUNT_LOW_BYTE(lb),
		.ALT_COUNT_HIGH_BYTE(ahb), .ALT_COUNT_LOW_BYTE(alb), .OVERFLOW_FLAG(flag),
		.OVERFLOW_IRQ(irq), .TIMER_TICK(), .COUNT_VALUE(cnt));
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ref_cnt <= 16'hFFFC;
			psc <= 3'h0;
		end else if (!cfg.halt_mode) begin
			psc <= psc + 3'h1;
			ref_cnt <= (acc.wr_low || acc.wr_alt_low) ? 16'hFFFC : ref_cnt + 16'((psc & msk) == msk);
		end
	end
	task automatic op(input int b);
		@(negedge clk) req <= 7'h40 >> b;
		@(negedge clk) req <= '0;
		#1;
	endtask : op
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	initial begin
		repeat (3000) @(negedge clk);
		err_total++;
		summarize();
	end
	initial begin
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		cmp("count", 16'hFFFC, cnt);
		for (int s = 0; s < 3; s++) begin
			cfg.clock_select = 2'(s);
			repeat (40) @(negedge clk);
			cmp("count", ref_cnt, cnt);
		end
		op(0);
		cmp("high", 16'(ref_cnt[15:8]), 16'(hb));
		cmp("alt high", 16'(ref_cnt[15:8]), 16'(ahb));
		l = ref_cnt[7:0];
		op(0);
		repeat (5) @(negedge clk);
		op(4);
		cmp("alt low", 16'(l), 16'(alb));
		op(1);
		cmp("low", 16'(ref_cnt[7:0]), 16'(lb));
		$display("test read done");
		cfg = '{FRT_SEL_DIV2, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
		op(5);
		repeat (12) @(negedge clk);
		cmp("flag", 16'h1, 16'(flag));
		cmp("irq", 16'h0, 16'(irq));
		cfg.cpu_irq_mask = 1'b0;
		#1 cmp("irq", 16'h1, 16'(irq));
		op(4);
		op(1);
		cmp("flag", 16'h1, 16'(flag));
		op(6);
		op(1);
		@(negedge clk) cmp("flag", 16'h0, 16'(flag));
		cfg.halt_mode = 1'b1;
		repeat (20) @(negedge clk);
		cmp("halt", ref_cnt, cnt);
		cfg.halt_mode = 1'b0;
		repeat (20) @(negedge clk);
		cmp("run", ref_cnt, cnt);
		$display("test flag done");
		for (int e = 0; e < 3; e++) begin
			cfg = '{FRT_SEL_EXT, e[0], 1'b0, 1'b1, 1'b0, e < 2};
			repeat (5) @(negedge clk);
			op(2);
			edges = 0;
			run = 1'b1;
			repeat (60) @(negedge clk);
			run = 1'b0;
			repeat (8) @(negedge clk);
			cmp("ext", 16'(16'hFFFC + (e < 2 ? edges : 0)), cnt);
		end
		summarize();
	end
endmodule : testbench
`default_nettype wire
